// >>> core/ssdm_consts.vh
`ifndef SSDM_CONSTS_VH
`define SSDM_CONSTS_VH
// Global configuration word fields
`define SSDM_CFG_W         16
`define SSDM_CFG_SMS_BIT   0
`define SSDM_CFG_DIR_POS   2
`define SSDM_CFG_DIR_NEG   3
`define SSDM_CFG_NOP_POS   10
`define SSDM_CFG_NOP_NEG   11
// Safety operating status codes
`define SSDM_ST_W          3
`define SSDM_ST_NORMAL     3'h0
`define SSDM_ST_STOP1      3'h1
`define SSDM_ST_STOP2      3'h2
`define SSDM_ST_ESTOP      3'h3
`define SSDM_ST_MOTION     3'h4
`define SSDM_ST_STO        3'h5
// Password levels
`define SSDM_PWL_W         2
`define SSDM_PWL_NONE      2'h0
`define SSDM_PWL_SAFETY    2'h1
`endif

// >>> core/ssdm_channel.v
`timescale 1ns/100ps
// One supervision channel; both channels are identical instances
module ssdm_channel #(
  parameter VW = 32
) (
  // Clock and reset
  input  wire          clk_sys,
  input  wire          sys_rst,
  // Inputs
  input  wire          en_speed,
  input  wire          en_dir,
  input  wire          dir_pos,
  input  wire [VW-1:0] max_speed,
  input  wire [VW-1:0] window,
  input  wire [VW-1:0] vel,
  input  wire [VW-1:0] neg_travel,
  input  wire [VW-1:0] pos_travel,
  // Results
  output reg           speed_viol,
  output reg           dir_viol
);
  wire [VW-1:0] speed_mag;
  assign speed_mag = vel[VW-1] ? (~vel + {{(VW-1){1'b0}}, 1'b1}) : vel;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      speed_viol <= 1'b0;
      dir_viol   <= 1'b0;
    end else begin
      speed_viol <= en_speed && (speed_mag > max_speed);
      // Travel counted in the disabled direction since reference
      dir_viol   <= en_dir && ((dir_pos ? neg_travel : pos_travel) > window);
    end
  end
endmodule

// >>> core/ssdm_monitor.v
`timescale 1ns/100ps
`include "ssdm_consts.vh"
// How it works
// - Speed beyond limit raises overspeed, shutdown
// - Speed supervision runs in every status
// - Limit locked after activation without password
// - Wrong-direction travel beyond window trips shutdown
// - Direction supervision self-starts after activation
// - Bits 10/11 limit direction to normal
// - Direction kept until new status reached
// - Bits 2/3 also cover stop modes
module ssdm_monitor #(
  parameter VW = 32
) (
  // Clock and reset
  input  wire                    clk_sys,
  input  wire                    sys_rst,
  // Configuration
  input  wire [`SSDM_CFG_W-1:0]  cfg_word,
  input  wire                    safety_active,
  input  wire                    password_ok,
  input  wire                    limit_wr,
  input  wire [VW-1:0]           limit_wdata,
  input  wire [VW-1:0]           standstill_window,
  // Operating status
  input  wire [`SSDM_ST_W-1:0]   status_req,
  input  wire [`SSDM_ST_W-1:0]   status_reached,
  // Feedback
  input  wire signed [VW-1:0]    act_velocity,
  input  wire signed [VW-1:0]    act_position,
  // Status and shutdown
  output reg  [VW-1:0]           max_speed_limit,
  output reg                     limit_wr_rejected,
  output reg  [`SSDM_PWL_W-1:0]  password_level,
  output reg                     overspeed_error,
  output reg                     wrong_direction_error,
  output reg                     drive_shutdown
);
  // Direction supervision states
  localparam [2:0] DIR_OFF    = 3'b001;
  localparam [2:0] DIR_NORMAL = 3'b010;
  localparam [2:0] DIR_STOP   = 3'b100;

  // Position reference for travel in the disabled direction
  reg              [VW-1:0] ref_pos;
  // Direction supervision state
  reg              [2:0]    dir_state;
  reg              [2:0]    next_dir_state;
  wire                      dir_active;
  // Travel since the reference
  wire             [VW-1:0] delta;
  wire             [VW-1:0] pos_trv;
  wire             [VW-1:0] neg_trv;
  wire                      moving_allowed;
  // Configuration decode
  wire                      dir_cfg_pos;
  wire                      dir_cfg_any;
  wire                      dir_cfg_nop;
  wire                      speed_cfg;
  // Limit write decode
  wire                      limit_unlocked;
  wire                      limit_accept;
  wire                      limit_refuse;
  // Channel results
  wire             [1:0]    sv;
  wire             [1:0]    dv;
  wire                      any_speed_viol;
  wire                      any_dir_viol;

  // Normal-only bits name an allowed direction just like the full-scope bits
  assign dir_cfg_pos = cfg_word[`SSDM_CFG_DIR_POS] | cfg_word[`SSDM_CFG_NOP_POS];
  assign dir_cfg_any = cfg_word[`SSDM_CFG_DIR_POS] | cfg_word[`SSDM_CFG_DIR_NEG];
  assign dir_cfg_nop = cfg_word[`SSDM_CFG_NOP_POS] | cfg_word[`SSDM_CFG_NOP_NEG];
  assign speed_cfg   = cfg_word[`SSDM_CFG_SMS_BIT];

  assign limit_unlocked = !safety_active || password_ok;
  assign limit_accept   = limit_wr && limit_unlocked;
  assign limit_refuse   = limit_wr && !limit_unlocked;

  assign delta   = act_position - ref_pos;
  assign pos_trv = delta[VW-1] ? {VW{1'b0}} : delta;
  assign neg_trv = delta[VW-1] ? (~delta + {{(VW-1){1'b0}}, 1'b1}) : {VW{1'b0}};
  assign moving_allowed = dir_cfg_pos ? !delta[VW-1] : delta[VW-1];

  assign dir_active = (dir_state != DIR_OFF);

  assign any_speed_viol = |sv;
  assign any_dir_viol   = |dv;

  // Follows the reached status, so a pending change keeps the old supervision
  always @* begin
    next_dir_state = DIR_OFF;
    if (safety_active) begin
      case (status_reached)
        `SSDM_ST_NORMAL: begin
          if (dir_cfg_any || dir_cfg_nop)
            next_dir_state = DIR_NORMAL;
        end
        `SSDM_ST_STOP1,
        `SSDM_ST_STOP2,
        `SSDM_ST_ESTOP: begin
          if (dir_cfg_any)
            next_dir_state = DIR_STOP;
        end
        default: begin
          next_dir_state = DIR_OFF;
        end
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_state <= DIR_OFF;
    end else begin
      dir_state <= next_dir_state;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      ssdm_channel #(.VW(VW)) u_ch (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .en_speed   (speed_cfg),
        .en_dir     (dir_active),
        .dir_pos    (dir_cfg_pos),
        .max_speed  (max_speed_limit),
        .window     (standstill_window),
        .vel        (act_velocity),
        .neg_travel (neg_trv),
        .pos_travel (pos_trv),
        .speed_viol (sv[ch]),
        .dir_viol   (dv[ch])
      );
    end
  endgenerate

  // Limit register; a locked write leaves it untouched
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      max_speed_limit <= {VW{1'b0}};
    end else begin
      if (limit_accept)
        max_speed_limit <= limit_wdata;
    end
  end

  // One-cycle refusal flag per locked write
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      limit_wr_rejected <= 1'b0;
    end else begin
      limit_wr_rejected <= limit_refuse;
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      password_level <= `SSDM_PWL_NONE;
    end else begin
      password_level <= password_ok ? `SSDM_PWL_SAFETY : `SSDM_PWL_NONE;
    end
  end

  // Reference follows position while unsupervised or moving the allowed way
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ref_pos <= {VW{1'b0}};
    end else begin
      if (!dir_active || moving_allowed)
        ref_pos <= act_position;
    end
  end

  // Fatal errors latch until reset; no clear path on purpose
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      overspeed_error <= 1'b0;
    end else begin
      if (any_speed_viol)
        overspeed_error <= 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      wrong_direction_error <= 1'b0;
    end else begin
      if (any_dir_viol)
        wrong_direction_error <= 1'b1;
    end
  end

  // Either channel alone shuts the drive down
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      drive_shutdown <= 1'b0;
    end else begin
      if (any_speed_viol || any_dir_viol)
        drive_shutdown <= 1'b1;
    end
  end
endmodule

// >>> test/ssdm_assertions.sv
`timescale 1ns/100ps
module ssdm_assertions #(parameter VW = 32) (
  input wire clk_sys, sys_rst, limit_wr, safety_active, password_ok,
  input wire [15:0] cfg_word,
  input wire signed [VW-1:0] act_velocity,
  input wire [VW-1:0] limit_wdata, max_speed_limit,
  input wire limit_wr_rejected, overspeed_error, wrong_direction_error, drive_shutdown
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire [VW-1:0] spd = act_velocity[VW-1] ? -act_velocity : act_velocity;
  wire over = cfg_word[0] && (spd > max_speed_limit);
  property p_acc; limit_wr && (!safety_active || password_ok) |=> max_speed_limit == $past(limit_wdata); endproperty
  a_acc: assert property (p_acc) else $error("limit write lost");
  property p_rej; limit_wr && safety_active && !password_ok |=> limit_wr_rejected && $stable(max_speed_limit); endproperty
  a_rej: assert property (p_rej) else $error("locked write not refused");
  property p_norej; !limit_wr |=> !limit_wr_rejected; endproperty
  a_norej: assert property (p_norej) else $error("spurious refusal");
  property p_ovs; over |-> ##2 overspeed_error; endproperty
  a_ovs: assert property (p_ovs) else $error("overspeed missed");
  property p_nofalse; $rose(overspeed_error) |-> $past(over, 2); endproperty
  a_nofalse: assert property (p_nofalse) else $error("false overspeed");
  property p_ovs_sd; overspeed_error |-> drive_shutdown; endproperty
  a_ovs_sd: assert property (p_ovs_sd) else $error("no shutdown on overspeed");
  property p_dir_sd; wrong_direction_error |-> drive_shutdown; endproperty
  a_dir_sd: assert property (p_dir_sd) else $error("no shutdown on direction");
  property p_hold; drive_shutdown |=> drive_shutdown; endproperty
  a_hold: assert property (p_hold) else $error("shutdown dropped");
endmodule
bind ssdm_monitor ssdm_assertions #(.VW(VW)) i_chk (.clk_sys, .sys_rst, .limit_wr, .safety_active,
  .password_ok, .cfg_word, .act_velocity, .limit_wdata, .max_speed_limit, .limit_wr_rejected,
  .overspeed_error, .wrong_direction_error, .drive_shutdown);

// >>> test/ssdm_drive_model.sv
`timescale 1ns/100ps
module ssdm_drive_model #(parameter VW = 32) (
  input wire clk_sys, sys_rst, drive_shutdown,
  input wire signed [VW-1:0] cmd_vel,
  output reg signed [VW-1:0] act_velocity, act_position
);
  // Shutdown zeroes the velocity at the next clock edge
  always @(posedge clk_sys) begin
    act_velocity <= (sys_rst || drive_shutdown) ? {VW{1'b0}} : cmd_vel;
    act_position <= sys_rst ? {VW{1'b0}} : act_position + act_velocity;
  end
endmodule

// >>> test/safe_speed_direction_monitor_tb_top.sv
`timescale 1ns/100ps
`include "ssdm_consts.vh"
module safe_speed_direction_monitor_tb_top;
  reg clk_sys = 0, sys_rst = 1, safety_active = 0, password_ok = 0, limit_wr = 0;
  reg [15:0] cfg_word = 16'h0000;
  reg [2:0] status_reached = 3'h0, status_req = 3'h0;
  reg [31:0] limit_wdata = 32'h0, cmd_vel = 32'h0;
  wire [31:0] act_velocity, act_position, max_speed_limit;
  wire [1:0] password_level;
  wire limit_wr_rejected, overspeed_error, wrong_direction_error, drive_shutdown;
  integer err_count = 0, compares = 0;
  always #4 clk_sys = ~clk_sys;
  ssdm_drive_model i_drv (.clk_sys, .sys_rst, .drive_shutdown, .cmd_vel, .act_velocity,
    .act_position);
  ssdm_monitor i_dut (.clk_sys, .sys_rst, .cfg_word, .safety_active, .password_ok, .limit_wr,
    .limit_wdata, .standstill_window(32'h10), .status_req, .status_reached,
    .act_velocity, .act_position, .max_speed_limit, .limit_wr_rejected, .password_level,
    .overspeed_error, .wrong_direction_error, .drive_shutdown);
  task cyc(input integer n); repeat (n) @(posedge clk_sys); endtask
  task chk(input [31:0] g, input [31:0] e); begin
    compares = compares + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  end endtask
  task rst; begin sys_rst <= 1; cmd_vel <= 0; cyc(6); sys_rst <= 0; cyc(1); end endtask
  task wr(input [31:0] d, input e); begin
    limit_wdata <= d; limit_wr <= 1; cyc(1); limit_wr <= 0;
    #1 chk(limit_wr_rejected, e);
    cyc(1);
  end endtask
  task t_limit; begin
    rst; wr(32'h100, 0); chk(max_speed_limit, 32'h100);
    safety_active <= 1; wr(32'h200, 1); chk(max_speed_limit, 32'h100);
    password_ok <= 1; wr(32'h200, 0); chk(max_speed_limit, 32'h200);
    chk(password_level, `SSDM_PWL_SAFETY);
  end endtask
  task t_speed; begin
    rst; cfg_word <= 16'h0001; status_reached <= `SSDM_ST_STOP1; wr(32'h100, 0);
    cmd_vel <= 32'h100; cyc(6); chk(overspeed_error, 0);
    cmd_vel <= 32'hFFFF_FEFF; cyc(4); chk(overspeed_error, 1);
    chk(drive_shutdown, 1);
  end endtask
  task t_dir(input [15:0] c, input [2:0] s, input [31:0] v, input e); begin
    rst; safety_active <= 1; cfg_word <= c; status_reached <= s; status_req <= s; cyc(2);
    cmd_vel <= v; cyc(12); chk(wrong_direction_error, e);
    chk(drive_shutdown, e);
  end endtask
  task t_pending; begin
    rst; safety_active <= 1; cfg_word <= 16'h0400; status_reached <= `SSDM_ST_NORMAL;
    status_req <= `SSDM_ST_STOP1; cyc(2);
    cmd_vel <= 32'hFFFF_FFFC; cyc(12); chk(wrong_direction_error, 1);
  end endtask
  task close_out; begin
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end endtask
  initial begin
    t_limit;
    t_speed;
    t_dir(16'h0004, `SSDM_ST_NORMAL, 32'h8, 0);
    t_dir(16'h0004, `SSDM_ST_NORMAL, 32'hFFFF_FFFC, 1);
    t_dir(16'h0004, `SSDM_ST_ESTOP, 32'hFFFF_FFFC, 1);
    t_dir(16'h0008, `SSDM_ST_STOP2, 32'h4, 1);
    t_dir(16'h0400, `SSDM_ST_STOP1, 32'hFFFF_FFFC, 0);
    t_dir(16'h0400, `SSDM_ST_NORMAL, 32'hFFFF_FFFC, 1);
    t_dir(16'h0800, `SSDM_ST_NORMAL, 32'h4, 1);
    t_dir(16'h0004, `SSDM_ST_MOTION, 32'hFFFF_FFFC, 0);
    t_pending;
    close_out;
  end
endmodule
